// ===== logic/link_quality_threshold_access.sv
// Purpose: access logic for the link quality data register and its limit checks
// Assumes: request, parameter and status inputs are synchronous to sys_clk
// Notes:   read data is registered; it appears the cycle after the read strobe
//          A read in the same cycle as a write returns the state before it
//          Limit writes are dropped silently, never queued for later
//          Warning flags are sticky; a crossing in the clearing cycle keeps its flag
//          Select codes above four address nothing and sample as zero
// Notes on behaviour
// - Bits 15:14 ignore writes and read back as zero.
// - Setting sample bit captures the selected live parameter into the data field.
// - Write bit stores data field into limit chosen by quantity and low/high.
// - Write bit always reads back as zero.
// - Three-bit quantity select, codes zero to four, five quantities.
// - Same quantity select chooses sampled parameter and addressed limit.
// - Low/high bit picks low or high limit; ten limits in total.
// - With sample bit clear, written data field is the limit value.
// - With sample bit clear, reads return the selected stored limit.
// - With sample bit set, reads return held sample until next sample request.
// - No limit changes while powered down; software programs only when up.
// - Crossing a limit sets its warning flag when monitor enabled with link up at 100, and interrupt when irq enabled.
module link_quality_threshold_access (
    input  wire logic                      sys_clk,
    input  wire logic                      arst_n,
    input  wire lq_access_pkg::mgmt_req_t  req,
    input  wire lq_access_pkg::param_vec_t param_values,
    input  wire logic                      power_down,
    input  wire logic                      monitor_enable,
    input  wire logic                      link_up_100,
    input  wire logic                      warn_clear,
    input  wire logic                      irq_enable,
    output      logic [15:0]               rdata,
    output      logic [9:0]                warn_flags,
    output      logic                      irq
);
    import lq_access_pkg::*;

    // Registered control fields and outputs
    logic                sample_r;
    logic                sample_nxt;
    monitored_quantity_t sel_r;
    monitored_quantity_t sel_nxt;
    logic                hilo_r;
    logic                hilo_nxt;
    logic [7:0]          sample_val_r;
    logic [7:0]          sample_val_nxt;
    logic [15:0]         rdata_r;
    logic [15:0]         rdata_nxt;
    logic [9:0]          warn_r;
    logic [9:0]          warn_nxt;
    logic                irq_r;
    logic                irq_nxt;

    // Request decode, limit addressing and compare results
    logic                hit;
    logic                wr_hit;
    logic                rd_hit;
    logic [2:0]          new_sel;
    logic                sel_ok;
    logic                thr_wr_en;
    logic [3:0]          thr_idx;
    logic [3:0]          rd_idx;
    logic [7:0]          thr_rd;
    thr_vec_t            thr_all;
    logic [9:0]          crossing;
    logic [7:0]          captured;
    logic [15:0]         read_word;

    // One register lives here; any other page or offset is ignored
    always_comb begin
        hit = 1'b0;
        if (req.page != LQ_DATA_PAGE) begin
            hit = 1'b0;
        end else if (req.addr == LQ_DATA_OFFSET) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end
    assign wr_hit = hit && req.wr;
    assign rd_hit = hit && req.rd;

    // Limit address uses the select fields carried by the same write
    assign new_sel   = req.wdata[SEL_HI:SEL_LO];
    assign sel_ok    = new_sel < 3'(NUM_PARAMS);
    assign thr_idx   = {new_sel, req.wdata[HILO_BIT]};
    assign rd_idx    = {sel_r, hilo_r};

    // Refusals are silent; a dropped strobe is never queued for later
    always_comb begin
        thr_wr_en = 1'b0;
        if (!wr_hit || !req.wdata[WRITE_BIT]) begin
            thr_wr_en = 1'b0;
        end else if (power_down) begin
            thr_wr_en = 1'b0;
        end else if (req.wdata[SAMPLE_BIT]) begin
            // Sampling owns the data field in this write
            thr_wr_en = 1'b0;
        end else if (!sel_ok) begin
            thr_wr_en = 1'b0;
        end else begin
            thr_wr_en = 1'b1;
        end
    end

    // Out-of-range selects capture zero rather than an undefined element
    always_comb begin
        captured = 8'h00;
        if (sel_ok) begin
            captured = param_values[new_sel];
        end
    end

    limit_store u_limit_store (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wr_en   (thr_wr_en),
        .wr_idx  (thr_idx),
        .wr_data (req.wdata[DATA_HI:DATA_LO]),
        .rd_idx  (rd_idx),
        .rd_data (thr_rd),
        .thr_all (thr_all)
    );

    // Control fields; write bit and reserved bits are never stored
    always_comb begin
        sample_nxt     = sample_r;
        sel_nxt        = sel_r;
        hilo_nxt       = hilo_r;
        sample_val_nxt = sample_val_r;
        if (wr_hit) begin
            sample_nxt = req.wdata[SAMPLE_BIT];
            sel_nxt    = monitored_quantity_t'(new_sel);
            hilo_nxt   = req.wdata[HILO_BIT];
            if (req.wdata[SAMPLE_BIT]) begin
                // Each sample request starts a new read sequence
                sample_val_nxt = captured;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_r     <= LQ_DATA_RESET[SAMPLE_BIT];
            sel_r        <= equalizer_coefficient;
            hilo_r       <= LQ_DATA_RESET[HILO_BIT];
            sample_val_r <= LQ_DATA_RESET[DATA_HI:DATA_LO];
        end else begin
            sample_r     <= sample_nxt;
            sel_r        <= sel_nxt;
            hilo_r       <= hilo_nxt;
            sample_val_r <= sample_val_nxt;
        end
    end

    // Read word assembled every cycle, loaded only on a read hit
    always_comb begin
        read_word                  = 16'h0000;
        read_word[SAMPLE_BIT]      = sample_r;
        read_word[SEL_HI:SEL_LO]   = sel_r;
        read_word[HILO_BIT]        = hilo_r;
        if (sample_r) begin
            read_word[DATA_HI:DATA_LO] = sample_val_r;
        end else begin
            read_word[DATA_HI:DATA_LO] = thr_rd;
        end
    end

    // Read data held until the next read of this register
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_hit) begin
            rdata_nxt = read_word;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= LQ_DATA_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Strict compares, so a low limit at 00h or a high limit at FFh can never trip
    genvar g;
    generate
        for (g = 0; g < NUM_PARAMS; g++) begin : g_cmp
            logic [7:0] live;
            logic [7:0] low_lim;
            logic [7:0] high_lim;
            assign live            = param_values[g];
            assign low_lim         = thr_all[2*g];
            assign high_lim        = thr_all[2*g+1];
            assign crossing[2*g]   = live < low_lim;
            assign crossing[2*g+1] = live > high_lim;
        end
    endgenerate

    // Set beats clear so a crossing during the clearing read survives
    always_comb begin
        warn_nxt = warn_r & ~{10{warn_clear}};
        if (monitor_enable && link_up_100) begin
            warn_nxt = warn_nxt | crossing;
        end
        irq_nxt = irq_enable && (|warn_nxt);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            warn_r <= 10'h000;
            irq_r  <= 1'b0;
        end else begin
            warn_r <= warn_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign rdata      = rdata_r;
    assign warn_flags = warn_r;
    assign irq        = irq_r;
endmodule

// ===== logic/lq_access_pkg.sv
// Purpose: shared constants and carriers for the link quality data register block
// Assumes: management requests arrive on sys_clk, one cycle per strobe
// Notes:   bit positions follow the 16-bit data register layout
package lq_access_pkg;
    localparam logic [4:0]  LQ_DATA_OFFSET   = 5'h1E;
    localparam logic [2:0]  LQ_DATA_PAGE     = 3'h2;
    localparam logic [15:0] LQ_DATA_RESET    = 16'h0000;
    localparam int          RSVD_HI          = 15;
    localparam int          RSVD_LO          = 14;
    localparam int          SAMPLE_BIT       = 13;
    localparam int          WRITE_BIT        = 12;
    localparam int          SEL_HI           = 11;
    localparam int          SEL_LO           = 9;
    localparam int          HILO_BIT         = 8;
    localparam int          DATA_HI          = 7;
    localparam int          DATA_LO          = 0;
    localparam int          NUM_PARAMS       = 5;
    localparam int          NUM_THRESHOLDS   = 10;
    localparam logic [7:0]  LOW_THR_RESET    = 8'h00;
    localparam logic [7:0]  HIGH_THR_RESET   = 8'hFF;

    typedef enum logic [2:0] {
        equalizer_coefficient,
        digital_gain_control,
        baseline_wander_correction,
        frequency_offset,
        frequency_control
    } monitored_quantity_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  page;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef logic [NUM_PARAMS-1:0][7:0]     param_vec_t;
    typedef logic [NUM_THRESHOLDS-1:0][7:0] thr_vec_t;
endpackage

// ===== logic/limit_store.sv
// Purpose: ten 8-bit limit registers, low/high per monitored quantity
// Assumes: index is {quantity, low_high}; bad write indices filtered by caller, bad read indices return zero
// Notes:   even entries are low limits, odd entries high limits
module limit_store (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic                    wr_en,
    input  wire logic [3:0]              wr_idx,
    input  wire logic [7:0]              wr_data,
    input  wire logic [3:0]              rd_idx,
    output      logic [7:0]              rd_data,
    output      lq_access_pkg::thr_vec_t thr_all
);
    import lq_access_pkg::*;

    thr_vec_t thr_r;
    thr_vec_t thr_nxt;

    always_comb begin
        thr_nxt = thr_r;
        if (wr_en) begin
            thr_nxt[wr_idx] = wr_data;
        end
    end

    // Reset leaves every check disarmed: low at minimum, high at maximum
    genvar g;
    generate
        for (g = 0; g < NUM_THRESHOLDS; g++) begin : g_thr
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    thr_r[g] <= (g % 2 == 0) ? LOW_THR_RESET : HIGH_THR_RESET;
                end else begin
                    thr_r[g] <= thr_nxt[g];
                end
            end
        end
    endgenerate

    assign rd_data = (rd_idx < 4'(NUM_THRESHOLDS)) ? thr_r[rd_idx] : 8'h00;
    assign thr_all = thr_r;
endmodule

// ===== test/lq_checker.sv
// Purpose: port assertions for link quality register access
// Assumes: one clock domain, async active-low reset
// Notes:   sample expectation kept in a helper flop
module lq_checker (
    input wire logic                      sys_clk,
    input wire logic                      arst_n,
    input wire lq_access_pkg::mgmt_req_t  req,
    input wire lq_access_pkg::param_vec_t param_values,
    input wire logic                      power_down,
    input wire logic                      monitor_enable,
    input wire logic                      link_up_100,
    input wire logic                      warn_clear,
    input wire logic                      irq_enable,
    input wire logic [15:0]               rdata,
    input wire logic [9:0]                warn_flags,
    input wire logic                      irq
);
    import lq_access_pkg::*;
    logic       hit;
    logic       rd_only;
    logic [7:0] smp_r;
    assign hit = (req.rd | req.wr) && req.page == LQ_DATA_PAGE && req.addr == LQ_DATA_OFFSET;
    assign rd_only = hit && req.rd && !req.wr;
    // Free-running; only trusted right after a sampling write
    always_ff @(posedge sys_clk) smp_r <= param_values[req.wdata[11:9]];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    rsvd_zero_a: assert property (rdata[15:14] == 2'h0)
        else $error("reserved bits not zero");
    wbit_zero_a: assert property (rdata[12] == 1'b0)
        else $error("write bit reads back set");
    rdata_hold_a: assert property (!(hit && req.rd) |=> $stable(rdata))
        else $error("read data moved without a read");
    sample_read_a: assert property (hit && req.wr && req.wdata[13] && req.wdata[11:9] < 3'h5 ##1 rd_only
        |=> rdata == {4'h2, $past(req.wdata[11:8], 2), $past(smp_r)}) else $error("sample readback wrong");
    limit_rw_a: assert property (hit && req.wr && req.wdata[13:12] == 2'h1 && req.wdata[11:9] < 3'h5
        && !power_down ##1 rd_only |=> rdata == {4'h0, $past(req.wdata[11:0], 2)}) else $error("limit readback wrong");
    irq_follow_a: assert property (irq == ($past(irq_enable) && (|warn_flags)))
        else $error("irq not matching flags");
    warn_keep_a: assert property (!(monitor_enable && link_up_100) && !warn_clear |=> $stable(warn_flags))
        else $error("flags moved while monitor off");
    warn_clr_a: assert property (warn_clear && !monitor_enable |=> warn_flags == 10'h000)
        else $error("flags not cleared");
endmodule

bind link_quality_threshold_access lq_checker chk (.sys_clk, .arst_n, .req, .param_values, .power_down,
    .monitor_enable, .link_up_100, .warn_clear, .irq_enable, .rdata, .warn_flags, .irq);

// ===== test/tb_top.sv
// Purpose: directed bench for link quality register access
// Assumes: inputs change on the falling edge
// Notes:   expectations built from the register layout
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lq_access_pkg::*;
    logic        sys_clk, arst_n, power_down, monitor_enable, link_up_100, warn_clear, irq_enable;
    mgmt_req_t   req;
    param_vec_t  param_values;
    logic [15:0] rdata;
    logic [9:0]  warn_flags;
    logic        irq;
    int          n_errors, compares;
    link_quality_threshold_access dut (.sys_clk, .arst_n, .req, .param_values, .power_down,
        .monitor_enable, .link_up_100, .warn_clear, .irq_enable, .rdata, .warn_flags, .irq);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held one edge; caller's next access replaces it
    task automatic acc(input logic r, input logic w, input logic [15:0] d, input logic [4:0] a);
        req = '{rd: r, wr: w, page: LQ_DATA_PAGE, addr: a, wdata: d};
        @(negedge sys_clk);
    endtask
    task automatic wr_reg(input logic [15:0] d);
        acc(1'b0, 1'b1, d, LQ_DATA_OFFSET);
    endtask
    task automatic rd_chk(input logic [15:0] exp);
        acc(1'b1, 1'b0, 16'h0000, LQ_DATA_OFFSET);
        chk(rdata, exp);
    endtask
    task automatic t_disarm;
        param_values = {8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF};
        {monitor_enable, link_up_100} = 2'h3;
        repeat (2) @(negedge sys_clk);
        chk({irq, 5'h00, warn_flags}, 16'h0000);
        {monitor_enable, link_up_100} = 2'h0;
        param_values = '0;
    endtask
    task automatic t_limits;
        rd_chk(LQ_DATA_RESET);
        for (int i = 0; i < 10; i++) begin
            wr_reg({4'h0, i[3:0], 8'h00});
            rd_chk({4'h0, i[3:0], (i % 2) ? HIGH_THR_RESET : LOW_THR_RESET});
        end
        for (int i = 0; i < 10; i++) wr_reg({4'hD, i[3:0], 8'h40 + i[7:0]});
        for (int i = 0; i < 10; i++) begin
            wr_reg({4'h0, i[3:0], 8'h00});
            rd_chk({4'h0, i[3:0], 8'h40 + i[7:0]});
        end
        wr_reg({4'h1, 4'hA, 8'h77});
        rd_chk(16'h0A00);
    endtask
    task automatic t_power;
        power_down = 1'b1;
        wr_reg({4'h1, 4'h3, 8'hEE});
        power_down = 1'b0;
        rd_chk({4'h0, 4'h3, 8'h43});
        wr_reg({4'h1, 4'h3, 8'hEE});
        rd_chk({4'h0, 4'h3, 8'hEE});
    endtask
    task automatic t_sample;
        for (int s = 0; s < 5; s++) begin
            param_values = {8'h15, 8'h14, 8'h13, 8'h12, 8'h11};
            wr_reg({4'h2, s[2:0], 1'b1, 8'h00});
            param_values = ~param_values;
            rd_chk({4'h2, s[2:0], 1'b1, 8'h11 + s[7:0]});
            rd_chk({4'h2, s[2:0], 1'b1, 8'h11 + s[7:0]});
        end
        acc(1'b1, 1'b0, 16'h0000, 5'h1D);
        chk(rdata, {4'h2, 3'h4, 1'b1, 8'h15});
    endtask
    task automatic t_warn;
        req = '0;
        param_values = {8'h48, 8'h46, 8'h44, 8'h10, 8'h40};
        {monitor_enable, link_up_100, irq_enable} = 3'h7;
        @(negedge sys_clk);
        param_values[1] = 8'h42;
        @(negedge sys_clk);
        chk({irq, 5'h00, warn_flags}, 16'h8004);
        monitor_enable = 1'b0;
        warn_clear = 1'b1;
        @(negedge sys_clk);
        warn_clear = 1'b0;
        chk({irq, 5'h00, warn_flags}, 16'h0000);
        param_values[4] = 8'h50;
        monitor_enable = 1'b1;
        {link_up_100, irq_enable} = 2'h0;
        @(negedge sys_clk);
        chk({irq, 5'h00, warn_flags}, 16'h0000);
        link_up_100 = 1'b1;
        @(negedge sys_clk);
        chk({irq, 5'h00, warn_flags}, 16'h0200);
        warn_clear = 1'b1;
        @(negedge sys_clk);
        warn_clear = 1'b0;
        irq_enable = 1'b1;
        chk({irq, 5'h00, warn_flags}, 16'h0200);
        @(negedge sys_clk);
        chk({irq, 5'h00, warn_flags}, 16'h8200);
    endtask
    task automatic close_out;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Whole run is under a hundred cycles
    initial begin
        #50us;
        n_errors++;
        close_out();
    end
    initial begin
        arst_n = 1'b0;
        req = '0;
        param_values = '0;
        {power_down, monitor_enable, link_up_100, warn_clear, irq_enable} = 5'h00;
        n_errors = 0;
        compares = 0;
        repeat (10) @(negedge sys_clk);
        arst_n = 1'b1;
        t_disarm();
        t_limits();
        t_power();
        t_sample();
        t_warn();
        close_out();
    end
endmodule
